//--- design/clkmgr_pkg.sv
// clock manager constants and carriers
package clkmgr_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int REF_LOST_NS = 1000;
  localparam int REF_LOST_CYC = REF_LOST_NS / CLK_NS;
  localparam logic [3:0] LOCK_EDGES = 4'h8;
  // ------------------------------------------------------------
  // sizes and pin indices
  // ------------------------------------------------------------
  localparam int NUM_LOOPS = 4;
  localparam int LVDS_LOOPS = 2;
  localparam int FAST_IO_PIN_A = 0;
  localparam int FAST_IO_PIN_B = 1;
  localparam int FAST_IO_PIN_C = 2;
  localparam int FAST_IO_PIN_D = 3;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_MASK = 12'h008;
  localparam logic [11:0] ADDR_STATE = 12'h00c;
  localparam logic [11:0] ADDR_LOOP_BASE = 12'h020;
  localparam logic [11:0] ADDR_LOOP_END = 12'h060;
  localparam logic [3:0] OFS_MUL = 4'h0;
  localparam logic [3:0] OFS_SHIFT = 4'h4;
  localparam int STAT_LOCK_LSB = 0;
  localparam int STAT_LOST_LSB = 4;
  localparam int STAT_ERR_BIT = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [26:0] MUL_RST = 27'h022_0202;
  localparam logic [7:0] MK_MIN = 8'h02;
  localparam logic [7:0] MK_MAX = 8'ha0;
  localparam logic [4:0] NV_MIN = 5'h01;
  localparam logic [4:0] NV_MAX = 5'h10;
  localparam logic [1:0] MULT_X1 = 2'h0;
  localparam logic [1:0] MULT_X2 = 2'h1;
  localparam logic [1:0] MULT_X4 = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {AX_IDLE = 2'b01, AX_BUSY = 2'b10} ax_state_t;
  typedef struct packed {
    logic use_v;
    logic [4:0] v;
    logic [4:0] n;
    logic [7:0] k;
    logic [7:0] m;
  } loop_mul_t;
  typedef struct packed {
    logic enable;
    logic lvds;
    logic fb_ext;
    logic gpio_oe;
    logic gpio_out;
    logic lock_out_en;
    logic src;
    logic early;
    logic [4:0] delay;
    logic [1:0] phase;
  } loop_shift_t;
  typedef struct packed {
    logic lvds;
    logic fb_ext;
    logic early;
    logic [4:0] delay;
    logic [1:0] phase;
    logic [7:0] m;
    logic [11:0] div;
  } unit_cfg_t;
endpackage : clkmgr_pkg

//--- design/loop_lock_unit.sv
// one locking loop: lock, rate, phase, delay
`timescale 1ns/1ns
module loop_lock_unit #(
  parameter int DL = 32
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic ref_s,
  input wire logic fb_s,
  input wire clkmgr_pkg::unit_cfg_t cfg,
  output logic locked,
  output logic gen_clk,
  output logic bit_strobe
);
  typedef struct packed {
    logic ref_d, fb_d, fb_seen, raw_d, locked, gen, strobe;
    logic [5:0] gap;
    logic [3:0] edges;
    logic [15:0] acc;
    logic [1:0] tcnt;
    logic [4:0] pcnt, gper;
    logic [DL-1:0] dl;
  } unit_st_t;

  unit_st_t q, d;

  always_comb begin
    logic rise, frise, tick, raw;
    logic [1:0] ph;
    logic [4:0] eff;
    logic [15:0] acc_t;
    d = q;
    rise = ref_s & ~q.ref_d;
    frise = fb_s & ~q.fb_d;
    tick = q.acc >= {4'h0, cfg.div};
    ph = q.tcnt + cfg.phase;
    raw = ph[1];
    acc_t = tick ? q.acc - {4'h0, cfg.div} : q.acc;
    eff = 5'h0;
    d.ref_d = ref_s;
    d.fb_d = fb_s;
    if (!run) begin
      d = '0;
      d.ref_d = ref_s;
      d.fb_d = fb_s;
    end else begin
      if (frise) begin
        d.fb_seen = 1'b1;
      end
      if (rise) begin
        d.gap = 6'h0;
        d.fb_seen = 1'b0;
        // off-board feedback must echo every reference edge
        if (cfg.fb_ext && !q.fb_seen && !frise) begin
          d.edges = 4'h0;
        end else if (q.edges != clkmgr_pkg::LOCK_EDGES) begin
          d.edges = q.edges + 4'h1;
        end
        // rate limit: at most one tick per core cycle
        if (acc_t < 16'hf000) begin
          acc_t = acc_t + {6'h0, cfg.m, 2'h0};
        end
      end else if (q.gap != 6'(clkmgr_pkg::REF_LOST_CYC)) begin
        d.gap = q.gap + 6'h1;
      end else begin
        d.edges = 4'h0;
      end
      d.locked = d.edges == clkmgr_pkg::LOCK_EDGES;
      d.acc = acc_t;
      d.tcnt = q.tcnt + {1'b0, tick};
      d.raw_d = raw;
      d.dl = {q.dl[DL-2:0], raw};
      if (raw && !q.raw_d) begin
        d.pcnt = 5'h0;
        d.gper = q.pcnt;
      end else if (q.pcnt != 5'h1f) begin
        d.pcnt = q.pcnt + 5'h1;
      end
      eff = cfg.early ? q.gper - cfg.delay : cfg.delay;
      if (cfg.delay > q.gper) begin
        eff = cfg.early ? 5'h0 : q.gper;
      end
      d.gen = q.dl[eff];
      d.strobe = tick & cfg.lvds;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign locked = q.locked;
  assign gen_clk = q.gen;
  assign bit_strobe = q.strobe;
endmodule : loop_lock_unit

//--- design/clock_manager.sv
// clock manager top: loops, lock pins, fast pins, register slave
`timescale 1ns/1ns
// Contract
// - four fast pins bidirectional, distribute and drive
// - fast pin data and enable from fabric
// - shared second input disables first input
// - clock one multiplier never exceeds clock two
// - rate m/(n*k) or m/(n*v), ranges checked
// - phase set in quarter-period steps
// - delay earlier or later, at most one period
// - each loop drives its own lock indicator
// - lock pin optional, else plain I/O
// - enhanced loop ignores reference until configured
// - base loop locks during configuration already
// - clock out off-chip, feedback off-board
// - two loops multiply serial interface clock
module clock_manager (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic first_dedicated_clock_input,
  input wire logic second_dedicated_clock_input,
  input wire logic config_done,
  input wire logic [3:0] fb_pin_i,
  output logic [3:0] gen_clk_pin_o,
  output logic [1:0] bit_strobe_o,
  input wire logic [3:0] lock_pin_i,
  output logic [3:0] lock_pin_o,
  output logic [3:0] lock_pin_oe,
  input wire logic [3:0] fast_io_pin_i,
  output logic [3:0] fast_io_pin_o,
  output logic [3:0] fast_io_pin_oe,
  input wire logic [3:0] fabric_fast_out,
  input wire logic [3:0] fabric_fast_oe,
  output logic [3:0] fabric_fast_in,
  output logic irq,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [14:0] s1, s2;
    clkmgr_pkg::ax_state_t wst, rst;
    logic aw_got, w_got;
    logic [11:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic enh, shared;
    logic [1:0] m1, m2;
    logic [8:0] stat, mask;
    logic irq;
    clkmgr_pkg::loop_mul_t [3:0] mul;
    clkmgr_pkg::loop_shift_t [3:0] shf;
    logic [3:0] lock_ind, lock_o, lock_oe, gen_o;
    logic [1:0] strobe_o;
    logic [3:0] fast_o, fast_oe, fast_in;
  } st_t;

  st_t q, d;
  logic [3:0] u_lock, u_gen, u_strobe;
  logic [3:0] u_run, u_ref;
  clkmgr_pkg::unit_cfg_t [3:0] u_cfg;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] fac(input logic [1:0] code);
    fac = code == clkmgr_pkg::MULT_X4 ? 8'h04 :
          code == clkmgr_pkg::MULT_X2 ? 8'h02 : 8'h01;
  endfunction : fac

  function automatic logic pair_ok(input logic [1:0] c1, input logic [1:0] c2);
    pair_ok = c2 <= clkmgr_pkg::MULT_X4 && c1 <= c2;
  endfunction : pair_ok

  function automatic logic mul_ok(input clkmgr_pkg::loop_mul_t v);
    mul_ok = v.m >= clkmgr_pkg::MK_MIN && v.m <= clkmgr_pkg::MK_MAX &&
             v.k >= clkmgr_pkg::MK_MIN && v.k <= clkmgr_pkg::MK_MAX &&
             v.n >= clkmgr_pkg::NV_MIN && v.n <= clkmgr_pkg::NV_MAX &&
             v.v >= clkmgr_pkg::NV_MIN && v.v <= clkmgr_pkg::NV_MAX;
  endfunction : mul_ok

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction : merge

  function automatic logic is_loop(input logic [11:0] a);
    is_loop = a >= clkmgr_pkg::ADDR_LOOP_BASE && a < clkmgr_pkg::ADDR_LOOP_END;
  endfunction : is_loop

  function automatic logic [1:0] loop_idx(input logic [11:0] a);
    logic [11:0] r;
    r = a - clkmgr_pkg::ADDR_LOOP_BASE;
    loop_idx = r[5:4];
  endfunction : loop_idx

  // ------------------------------------------------------------
  // loops
  // ------------------------------------------------------------
  for (genvar g = 0; g < clkmgr_pkg::NUM_LOOPS; g++) begin : g_loop
    always_comb begin
      logic [1:0] code;
      logic [11:0] dv;
      code = q.shf[g].src ? q.m2 : q.m1;
      dv = 12'(q.mul[g].n * (q.mul[g].use_v ? q.mul[g].v : q.mul[g].k[4:0]));
      if (!q.mul[g].use_v) begin
        dv = 12'(q.mul[g].n * q.mul[g].k);
      end
      u_ref[g] = q.shf[g].src ? q.s2[1] : q.s2[0];
      // clock one idle while clock two shared
      u_run[g] = q.shf[g].enable && (q.shf[g].src || !q.shared) &&
                 (!q.enh || q.s2[2]);
      u_cfg[g].lvds = q.shf[g].lvds && g < clkmgr_pkg::LVDS_LOOPS;
      u_cfg[g].fb_ext = q.shf[g].fb_ext;
      u_cfg[g].early = q.shf[g].early;
      u_cfg[g].delay = q.shf[g].delay;
      u_cfg[g].phase = q.shf[g].phase;
      u_cfg[g].m = q.enh ? q.mul[g].m : fac(code);
      u_cfg[g].div = q.enh ? dv : 12'h001;
    end
    loop_lock_unit #(.DL(32)) u_unit (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .run(u_run[g]),
      .ref_s(u_ref[g]),
      .fb_s(q.s2[3+g]),
      .cfg(u_cfg[g]),
      .locked(u_lock[g]),
      .gen_clk(u_gen[g]),
      .bit_strobe(u_strobe[g])
    );
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [8:0] ev, clr;
    logic [31:0] w, rv;
    logic ok;
    logic [1:0] li;
    d = q;
    ev = '0;
    clr = '0;
    w = '0;
    rv = '0;
    ok = 1'b0;
    li = '0;
    d.s1 = {fast_io_pin_i, lock_pin_i, fb_pin_i, config_done,
            second_dedicated_clock_input, first_dedicated_clock_input};
    d.s2 = q.s1;
    // lock shown only after configuration
    d.lock_ind = u_lock & {4{q.s2[2]}};
    ev[3:0] = d.lock_ind & ~q.lock_ind;
    ev[7:4] = q.lock_ind & ~d.lock_ind;
    for (int i = 0; i < clkmgr_pkg::NUM_LOOPS; i++) begin
      if (q.shf[i].lock_out_en) begin
        d.lock_o[i] = q.lock_ind[i];
        d.lock_oe[i] = 1'b1;
      end else begin
        d.lock_o[i] = q.shf[i].gpio_out;
        d.lock_oe[i] = q.shf[i].gpio_oe;
      end
    end
    d.gen_o = u_gen;
    d.strobe_o = u_strobe[1:0];
    d.fast_o = fabric_fast_out;
    d.fast_oe = fabric_fast_oe;
    d.fast_in = q.s2[14:11];

    // write channel: address and data in either order
    if (q.wst == clkmgr_pkg::AX_IDLE) begin
      if (s_axi_awvalid && q.awready) begin
        d.aw_got = 1'b1;
        d.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
        d.w_got = 1'b1;
        d.wdata = s_axi_wdata;
        d.wstrb = s_axi_wstrb;
      end
      if (q.aw_got && q.w_got) begin
        d.aw_got = 1'b0;
        d.w_got = 1'b0;
        d.wst = clkmgr_pkg::AX_BUSY;
        d.bvalid = 1'b1;
        d.bresp = clkmgr_pkg::RESP_OKAY;
        li = loop_idx(q.waddr);
        if (q.waddr == clkmgr_pkg::ADDR_CTRL) begin
          w = merge({26'h0, q.m2, q.m1, q.shared, q.enh}, q.wdata, q.wstrb);
          if (pair_ok(w[3:2], w[5:4])) begin
            d.enh = w[0];
            d.shared = w[1];
            d.m1 = w[3:2];
            d.m2 = w[5:4];
          end else begin
            ev[clkmgr_pkg::STAT_ERR_BIT] = 1'b1;
          end
        end else if (q.waddr == clkmgr_pkg::ADDR_MASK) begin
          w = merge({23'h0, q.mask}, q.wdata, q.wstrb);
          d.mask = w[8:0];
        end else if (q.waddr == clkmgr_pkg::ADDR_STAT ||
                     q.waddr == clkmgr_pkg::ADDR_STATE) begin
          d.bresp = clkmgr_pkg::RESP_OKAY;
        end else if (is_loop(q.waddr) && q.waddr[3:0] == clkmgr_pkg::OFS_MUL) begin
          w = merge({5'h0, q.mul[li]}, q.wdata, q.wstrb);
          ok = mul_ok(w[26:0]);
          if (ok) begin
            d.mul[li] = w[26:0];
          end else begin
            ev[clkmgr_pkg::STAT_ERR_BIT] = 1'b1;
          end
        end else if (is_loop(q.waddr) && q.waddr[3:0] == clkmgr_pkg::OFS_SHIFT) begin
          w = merge({17'h0, q.shf[li]}, q.wdata, q.wstrb);
          d.shf[li] = w[14:0];
          if (w[14] && !w[8] && q.shared) begin
            ev[clkmgr_pkg::STAT_ERR_BIT] = 1'b1;
          end
        end else begin
          d.bresp = clkmgr_pkg::RESP_SLVERR;
        end
      end
    end else if (s_axi_bready) begin
      d.bvalid = 1'b0;
      d.wst = clkmgr_pkg::AX_IDLE;
    end
    d.awready = d.wst == clkmgr_pkg::AX_IDLE && !d.aw_got;
    d.wready = d.wst == clkmgr_pkg::AX_IDLE && !d.w_got;

    // read channel
    if (q.rst == clkmgr_pkg::AX_IDLE) begin
      if (s_axi_arvalid && q.arready) begin
        d.rst = clkmgr_pkg::AX_BUSY;
        d.rvalid = 1'b1;
        d.rresp = clkmgr_pkg::RESP_OKAY;
        li = loop_idx(s_axi_araddr);
        if (s_axi_araddr == clkmgr_pkg::ADDR_CTRL) begin
          rv = {26'h0, q.m2, q.m1, q.shared, q.enh};
        end else if (s_axi_araddr == clkmgr_pkg::ADDR_STAT) begin
          rv = {23'h0, q.stat};
          clr = q.stat;
        end else if (s_axi_araddr == clkmgr_pkg::ADDR_MASK) begin
          rv = {23'h0, q.mask};
        end else if (s_axi_araddr == clkmgr_pkg::ADDR_STATE) begin
          rv = {16'h0, q.s2[10:7], q.s2[14:11], 3'h0, q.s2[2], q.lock_ind};
        end else if (is_loop(s_axi_araddr) &&
                     s_axi_araddr[3:0] == clkmgr_pkg::OFS_MUL) begin
          rv = {5'h0, q.mul[li]};
        end else if (is_loop(s_axi_araddr) &&
                     s_axi_araddr[3:0] == clkmgr_pkg::OFS_SHIFT) begin
          rv = {17'h0, q.shf[li]};
        end else begin
          d.rresp = clkmgr_pkg::RESP_SLVERR;
        end
        d.rdata = rv;
      end
    end else if (s_axi_rready) begin
      d.rvalid = 1'b0;
      d.rst = clkmgr_pkg::AX_IDLE;
    end
    d.arready = d.rst == clkmgr_pkg::AX_IDLE && !(s_axi_arvalid && q.arready);

    // set wins over read-clear
    d.stat = (q.stat & ~clr) | ev;
    d.irq = |(d.stat & d.mask);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.wst <= clkmgr_pkg::AX_IDLE;
      q.rst <= clkmgr_pkg::AX_IDLE;
      q.enh <= clkmgr_pkg::CTRL_RST[0];
      q.mul <= {4{clkmgr_pkg::MUL_RST}};
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign gen_clk_pin_o = q.gen_o;
  assign bit_strobe_o = q.strobe_o;
  assign lock_pin_o = q.lock_o;
  assign lock_pin_oe = q.lock_oe;
  assign fast_io_pin_o = q.fast_o;
  assign fast_io_pin_oe = q.fast_oe;
  assign fabric_fast_in = q.fast_in;
  assign irq = q.irq;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
endmodule : clock_manager

//--- tb/clock_manager_asserts.sv
// concurrent checks on clock manager ports
`timescale 1ns/1ns
module clock_manager_asserts (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [3:0] fabric_fast_out,
  input wire logic [3:0] fabric_fast_oe,
  input wire logic [3:0] fast_io_pin_o,
  input wire logic [3:0] fast_io_pin_oe,
  input wire logic [3:0] fast_io_pin_i,
  input wire logic [3:0] fabric_fast_in,
  input wire logic [1:0] bit_strobe_o,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  AST_FAST_OUT: assert property (
    $past(rst_b) |-> fast_io_pin_o == $past(fabric_fast_out))
    else $error("fast data lag");
  AST_FAST_OE: assert property (
    $past(rst_b) |-> fast_io_pin_oe == $past(fabric_fast_oe))
    else $error("fast enable lag");
  AST_FAST_IN: assert property (
    $past(rst_b, 3) && $past(rst_b, 2) && $past(rst_b) |-> fabric_fast_in == $past(fast_io_pin_i, 3))
    else $error("fast input lag");
  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  AST_B_LATENCY: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late");
  AST_B_DONE: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed");
  AST_AR_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  AST_R_DONE: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held");
  AST_RD_UNMAPPED: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr >= clkmgr_pkg::ADDR_LOOP_END
    |=> s_axi_rresp == clkmgr_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read accepted");
  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_SLVERR: cover property (s_axi_rvalid && s_axi_rresp == clkmgr_pkg::RESP_SLVERR);
  COV_STROBE: cover property (bit_strobe_o[0]);
endmodule : clock_manager_asserts

bind clock_manager clock_manager_asserts u_clock_manager_asserts (
  .core_clk, .rst_b, .fabric_fast_out, .fabric_fast_oe, .fast_io_pin_o, .fast_io_pin_oe,
  .fast_io_pin_i, .fabric_fast_in, .bit_strobe_o, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

//--- tb/ref_clock_src.sv
// reference clock source and feedback trace
`timescale 1ns/1ns
module ref_clock_src #(
  parameter int HALF = 8
) (
  input wire logic core_clk,
  input wire logic ref_run,
  input wire logic [3:0] gen_clk_pin_o,
  output logic first_dedicated_clock_input,
  output logic second_dedicated_clock_input,
  output logic [3:0] fb_pin_i
);
  int cnt = 0;
  logic ref_q = 1'b0;
  initial fb_pin_i = 4'h0;
  // a stopped source stands low, as an absent oscillator would
  always @(posedge core_clk) begin
    if (ref_run) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) ref_q <= ~ref_q;
    end else begin
      cnt <= 0;
      ref_q <= 1'b0;
    end
    // one cycle of trace delay
    fb_pin_i <= gen_clk_pin_o;
  end
  assign first_dedicated_clock_input = ref_q;
  assign second_dedicated_clock_input = ref_q;
endmodule : ref_clock_src

//--- tb/test_pll_clock_manager_fast_io.sv
// self-checking bench for the clock manager
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module test_pll_clock_manager_fast_io;
  logic core_clk, rst_b, config_done, ref_run, gen_prev;
  logic first_dedicated_clock_input, second_dedicated_clock_input;
  logic [3:0] fb_pin_i, gen_clk_pin_o, lock_pin_i, lock_pin_o, lock_pin_oe;
  logic [3:0] fast_io_pin_i, fast_io_pin_o, fast_io_pin_oe, ext_fast;
  logic [3:0] fabric_fast_out, fabric_fast_oe, fabric_fast_in, s_axi_wstrb;
  logic [1:0] bit_strobe_o, s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  logic irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d, keep;
  int err_count, checks, cyc, n_gen, n_stb, g0, s0;
  logic [31:0] mul_val [10] = '{32'h0210_a0a0, 32'h0421_0202, 32'h0021_02a1, 32'h0021_0201,
    32'h0021_0102, 32'h0021_a102, 32'h0020_0202, 32'h0031_0202, 32'h0001_0202, 32'h0221_0202};
  logic [9:0] mul_ok = 10'b00_0000_0011;
  // output rises in 32 reference periods
  logic [31:0] rate_val [2] = '{32'h0021_0204, 32'h0481_0204};
  int rate_exp [2] = '{64, 32};

  // undriven lock pins are pulled low, undriven fast pins take ext_fast
  assign lock_pin_i = lock_pin_oe & lock_pin_o;
  assign fast_io_pin_i = (fast_io_pin_oe & fast_io_pin_o) | (~fast_io_pin_oe & ext_fast);

  clock_manager u_clock_manager (
    .core_clk, .rst_b, .first_dedicated_clock_input, .second_dedicated_clock_input,
    .config_done, .fb_pin_i, .gen_clk_pin_o, .bit_strobe_o, .lock_pin_i, .lock_pin_o,
    .lock_pin_oe, .fast_io_pin_i, .fast_io_pin_o, .fast_io_pin_oe, .fabric_fast_out,
    .fabric_fast_oe, .fabric_fast_in, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  ref_clock_src u_ref_clock_src (.core_clk, .ref_run, .gen_clk_pin_o,
    .first_dedicated_clock_input, .second_dedicated_clock_input, .fb_pin_i);

  always #(clkmgr_pkg::CLK_NS / 2) core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (bit_strobe_o[0]) n_stb++;
    if (gen_clk_pin_o[0] && !gen_prev) n_gen++;
    gen_prev <= gen_clk_pin_o[0];
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("errors=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_cyc

  // bready and rready stay high
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    wr_r = s_axi_bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : axi_rd

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    axi_rd(a, rd_d, rd_r);
    `CHK(rd_d, exp)
  endtask : rd_chk

  // refused write keeps old value, sets error bit
  task automatic try_wr(input logic [11:0] a, input logic [31:0] v, input logic ok,
                        inout logic [31:0] old);
    axi_wr(a, v);
    if (ok) old = v;
    rd_chk(a, old);
    axi_rd(clkmgr_pkg::ADDR_STAT, rd_d, rd_r);
    `CHK(rd_d[8], !ok)
  endtask : try_wr
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    {core_clk, rst_b, config_done, gen_prev, ref_run} = 5'h01;
    {ext_fast, fabric_fast_out, fabric_fast_oe, s_axi_wstrb} = 16'h000f;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = 5'h03;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd_chk(clkmgr_pkg::ADDR_CTRL, clkmgr_pkg::CTRL_RST);
    rd_chk(clkmgr_pkg::ADDR_MASK, 32'h0);
    rd_chk(clkmgr_pkg::ADDR_STAT, 32'h0);
    rd_chk(12'h020, {5'h0, clkmgr_pkg::MUL_RST});
    rd_chk(12'h024, 32'h0);
    axi_wr(clkmgr_pkg::ADDR_STATE, 32'hffff_ffff);
    rd_chk(clkmgr_pkg::ADDR_STATE, 32'h0);
    axi_wr(12'h070, 32'h1);
    `CHK(wr_r, clkmgr_pkg::RESP_SLVERR)
    axi_rd(12'h070, rd_d, rd_r);
    `CHK(rd_r, clkmgr_pkg::RESP_SLVERR)
    fabric_fast_out <= 4'ha;
    fabric_fast_oe <= 4'h5;
    ext_fast <= 4'h6;
    wait_cyc(5);
    `CHK(fast_io_pin_o, 4'ha)
    `CHK(fast_io_pin_oe, 4'h5)
    `CHK(fabric_fast_in, (4'h5 & 4'ha) | (~4'h5 & 4'h6))
    rd_chk(clkmgr_pkg::ADDR_STATE, 32'h0000_0200);
    keep = clkmgr_pkg::CTRL_RST;
    for (int c2 = 0; c2 < 3; c2++) begin
      for (int c1 = 0; c1 < 3; c1++) begin
        try_wr(clkmgr_pkg::ADDR_CTRL, {26'h0, c2[1:0], c1[1:0], 2'b01}, c1 <= c2, keep);
      end
    end
    keep = {5'h0, clkmgr_pkg::MUL_RST};
    for (int i = 0; i < 10; i++) begin
      try_wr(12'h030, mul_val[i], mul_ok[i], keep);
    end
    // clock one barred while clock two is shared
    axi_wr(clkmgr_pkg::ADDR_CTRL, 32'h3);
    axi_wr(12'h054, 32'h4100);
    rd_chk(clkmgr_pkg::ADDR_STAT, 32'h0);
    axi_wr(12'h054, 32'h4000);
    rd_chk(clkmgr_pkg::ADDR_STAT, 32'h100);
    axi_wr(12'h054, 32'h0);
    axi_wr(clkmgr_pkg::ADDR_CTRL, 32'h1);
    axi_wr(12'h044, 32'h0c00);
    wait_cyc(3);
    `CHK({lock_pin_o[2], lock_pin_oe[2]}, 2'b11)
    wait_cyc(3);
    rd_chk(clkmgr_pkg::ADDR_STATE, 32'h0000_4200);
    axi_wr(12'h044, 32'h0);
    axi_wr(clkmgr_pkg::ADDR_MASK, 32'h1);
    axi_wr(12'h024, 32'h4200);
    wait_cyc(200);
    `CHK({lock_pin_o[0], lock_pin_oe[0], irq}, 3'b010)
    config_done <= 1'b1;
    wait_cyc(12);
    `CHK(lock_pin_o[0], 1'b0)
    wait_cyc(200);
    `CHK({lock_pin_o[0], irq}, 2'b11)
    rd_chk(clkmgr_pkg::ADDR_STATE, 32'h0000_1211);
    rd_chk(clkmgr_pkg::ADDR_STAT, 32'h1);
    wait_cyc(2);
    `CHK(irq, 1'b0)
    for (int i = 0; i < 2; i++) begin
      axi_wr(12'h020, rate_val[i]);
      axi_wr(12'h024, 32'h7200);
      wait_cyc(200);
      g0 = n_gen;
      s0 = n_stb;
      wait_cyc(32 * 2 * 8);
      `CHK((n_gen - g0) inside {[rate_exp[i] - 2 : rate_exp[i] + 2]}, 1'b1)
      `CHK((n_stb - s0) inside {[4 * rate_exp[i] - 3 : 4 * rate_exp[i] + 3]}, 1'b1)
    end
    `CHK(lock_pin_o[0], 1'b1)
    ref_run <= 1'b0;
    wait_cyc(40);
    `CHK(lock_pin_o[0], 1'b0)
    axi_rd(clkmgr_pkg::ADDR_STAT, rd_d, rd_r);
    `CHK(rd_d[4], 1'b1)
    ref_run <= 1'b1;
    config_done <= 1'b0;
    axi_wr(clkmgr_pkg::ADDR_CTRL, 32'h0);
    axi_wr(12'h024, 32'h4200);
    wait_cyc(200);
    `CHK(lock_pin_o[0], 1'b0)
    config_done <= 1'b1;
    wait_cyc(8);
    `CHK(lock_pin_o[0], 1'b1)
    end_sim();
  end
endmodule : test_pll_clock_manager_fast_io
